//--- rtl/asc_sequencer.v
// Sequencer and CPU interface of a 10-bit successive approximation
// converter, with single and scan modes and external trigger.
// Assumes an external analog mux, DAC and comparator driven from here;
// the comparator output and trigger pin are asynchronous.
//
// Contract
// [RL1] Trigger control resets and enters standby 0x7f
// [RL2] Bit 7 enables falling-edge trigger pin start
// [RL3] Trigger control bits 6-0 read one, ignore writes
// [RL4] Upper byte read returns byte, latches lower
// [RL5] Lower byte read returns the holding latch
// [RL6] Software reads upper byte before lower byte
// [RL7] Ten-bit successive approximation, single or scan
// [RL8] Single start converts once, start bit self-clears
// [RL9] Single end stores result, sets flag, interrupt
// [RL10] Flag clears on read-while-set then write zero
// [RL11] Software stops conversion before changing selection
// [RL12] Scan starts at group first, chains channels
// [RL13] Scan repeats cyclically until start bit cleared
// [RL14] Scan round end sets flag, restarts first
// [RL15] Scan restart after halt begins at first
// [RL16] Sync delay 10-17 slow, 6-9 fast states
// [RL17] Single conversion 259-266 or 131-134 states
// [RL18] Later scan conversions exactly 256 or 128
// [RL19] Enabled trigger falling edge sets start bit
// [RL20] Group bit picks inputs; low bits channel/count
// [RL21] Group inputs one to four map A-D
// [RL22] Result upper byte top bits; bits 5-0 zero
// [RL23] One-channel scan repeats, flag each conversion
`timescale 1ns/1ps
`include "asc_defines.vh"

module asc_sequencer #(
	parameter RES_W = 10
) (
	input  wire             clk_sys,
	input  wire             rstn,
	input  wire             ce,
	input  wire             standby,
	input  wire             periph_half,
	input  wire [7:0]       bus_addr,
	input  wire             bus_rd,
	input  wire             bus_wr,
	input  wire [7:0]       bus_wdata,
	output reg  [7:0]       bus_rdata,
	output reg              bus_rvalid,
	input  wire             trigger_pin_n,
	input  wire             cmp_in,
	output wire [2:0]       analog_sel,
	output wire             sample_hold,
	output wire [RES_W-1:0] dac_code,
	output wire             conv_end_irq
);
	localparam [1:0] ST_IDLE   = 2'd0;
	localparam [1:0] ST_DELAY  = 2'd1;
	localparam [1:0] ST_SAMPLE = 2'd2;
	localparam [1:0] ST_CONV   = 2'd3;

	// Remainder after delay and sampling, first and later scan conversions
	localparam [8:0] SLOW_REST1 = `ASC_SLOW_CONV_MAX - `ASC_SLOW_DLY_MAX
		- `ASC_SLOW_SAMPLE;
	localparam [8:0] FAST_REST1 = `ASC_FAST_CONV_MAX - `ASC_FAST_DLY_MAX
		- `ASC_FAST_SAMPLE;
	localparam [8:0] SLOW_REST2 = `ASC_SLOW_SCAN - `ASC_SLOW_SAMPLE;
	localparam [8:0] FAST_REST2 = `ASC_FAST_SCAN - `ASC_FAST_SAMPLE;
	// Reset image of the trigger register, so its enable bit can be picked
	localparam [7:0] TRIG_RST   = `ASC_TRIG_RST;

	// Address decode shared by the read strobe and the read pipeline
	function is_res;
		input [7:0] a;
		begin
			is_res = ({a[7:3], 3'b000} == `ASC_ADR_RES_BASE);
		end
	endfunction

	function [1:0] res_idx;
		input [7:0] a;
		begin
			res_idx = a[2:1];
		end
	endfunction

	wire srst = ~rstn | standby;

	// Control registers
	reg       flag_q, ie_q, start_q, scan_q, speed_q, group_q;
	reg [1:0] chan_q;
	reg       ext_en_q;
	reg       arm_q;
	reg [7:0] temp_q;

	// Sequencer registers
	reg [1:0]       st_q, st_d;
	reg [8:0]       cnt_q, cnt_d;
	reg [1:0]       idx_q, idx_d;
	reg             first_q, first_d;
	reg [RES_W-1:0] sar_q, sar_d;
	reg [3:0]       bit_q, bit_d;
	reg [2:0]       ph_q;
	reg             half_q;

	// Read pipeline
	reg       rd_p_q;
	reg [7:0] raddr_q;

	// Pin synchronisers
	reg trig_s1, trig_s2, trig_s3;
	reg cmp_s1, cmp_s2;

	// Sequencer outputs to the control path
	reg set_flag, clr_start, mem_we;

	wire [RES_W-1:0] mem_rdata;
	wire             tick  = ~periph_half | half_q;
	wire [1:0]       cur   = scan_q ? idx_q : chan_q;       // [RL20]
	wire [1:0]       last  = scan_q ? chan_q : 2'd0;
	wire             wr_ctrl = bus_wr & (bus_addr == `ASC_ADR_CTRL);
	wire             wr_trig = bus_wr & (bus_addr == `ASC_ADR_TRIG);
	wire             trig_fall = trig_s3 & ~trig_s2;
	wire             trig_go = trig_fall & ext_en_q;         // [RL2] [RL19]
	wire [8:0]       dly = speed_q
		? `ASC_FAST_DLY_MIN + {7'd0, ph_q[1:0]}
		: `ASC_SLOW_DLY_MIN + {6'd0, ph_q};
	wire [8:0]       smp = speed_q ? `ASC_FAST_SAMPLE : `ASC_SLOW_SAMPLE;

	assign analog_sel   = {group_q, cur};
	assign sample_hold  = (st_q == ST_SAMPLE);
	assign dac_code     = sar_q;
	assign conv_end_irq = flag_q & ie_q;                     // [RL9] [RL14]

	// Two flops on the comparator pin, three on the trigger pin; the last two trigger stages form the edge
	always @(posedge clk_sys) begin
		if (srst) begin
			trig_s1 <= 1'b1;
			trig_s2 <= 1'b1;
			trig_s3 <= 1'b1;
			cmp_s1  <= 1'b0;
			cmp_s2  <= 1'b0;
		end else if (ce) begin
			trig_s1 <= trigger_pin_n;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
			cmp_s1  <= cmp_in;
			cmp_s2  <= cmp_s1;
		end
	end

	// State pace: every clock, or every other one at half rate.
	// Phase counter makes the start delay depend on write timing.
	always @(posedge clk_sys) begin
		if (srst) begin
			half_q <= 1'b0;
			ph_q   <= 3'd0;
		end else if (ce) begin
			half_q <= ~half_q;
			if (tick)
				ph_q <= ph_q + 3'd1;                         // [RL16]
		end
	end

	// Sequencer next state
	always @* begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		idx_d     = idx_q;
		first_d   = first_q;
		sar_d     = sar_q;
		bit_d     = bit_q;
		set_flag  = 1'b0;
		clr_start = 1'b0;
		mem_we    = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (start_q) begin
					// The edge that leaves idle is the first delay state
					st_d    = ST_DELAY;
					cnt_d   = dly - 9'd1;                    // [RL16]
					idx_d   = 2'd0;                          // [RL12] [RL15]
					first_d = 1'b1;
				end
			end
			ST_DELAY: begin
				if (tick) begin
					if (cnt_q == 9'd1) begin
						st_d  = ST_SAMPLE;
						cnt_d = smp;                         // [RL17]
					end else begin
						cnt_d = cnt_q - 9'd1;
					end
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					if (cnt_q == 9'd1) begin
						st_d  = ST_CONV;
						sar_d = `ASC_SAR_MSB;                // [RL7]
						bit_d = 4'd9;
						if (first_q)                         // [RL17]
							cnt_d = speed_q ? FAST_REST1 : SLOW_REST1;
						else                                 // [RL18]
							cnt_d = speed_q ? FAST_REST2 : SLOW_REST2;
					end else begin
						cnt_d = cnt_q - 9'd1;
					end
				end
			end
			ST_CONV: begin
				if (tick) begin
					cnt_d = cnt_q - 9'd1;
					if (cnt_q == 9'd1) begin
						mem_we  = 1'b1;                      // [RL21]
						first_d = 1'b0;
						if (!scan_q) begin
							st_d      = ST_IDLE;
							clr_start = 1'b1;                // [RL8]
							set_flag  = 1'b1;                // [RL9]
						end else begin
							st_d  = ST_SAMPLE;               // [RL12] [RL13]
							cnt_d = smp;
							if (idx_q == last) begin
								set_flag = 1'b1;             // [RL14] [RL23]
								idx_d    = 2'd0;
							end else begin
								idx_d = idx_q + 2'd1;
							end
						end
					end else if (cnt_q <= `ASC_SAR_WINDOW &&
					             cnt_q[2:0] == 3'd0) begin
						// Gap of 8 states covers DAC settle and sync lag
						if (!cmp_s2)
							sar_d[bit_q] = 1'b0;             // [RL7]
						if (bit_q != 4'd0)
							sar_d[bit_q - 4'd1] = 1'b1;
						bit_d = bit_q - 4'd1;
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
		// Clearing the start bit halts any phase at once
		if (st_q != ST_IDLE && !start_q)
			st_d = ST_IDLE;                                  // [RL13] [RL15]
	end

	// Sequencer registers
	always @(posedge clk_sys) begin
		if (srst) begin
			st_q    <= ST_IDLE;
			cnt_q   <= 9'd0;
			idx_q   <= 2'd0;
			first_q <= 1'b1;
			sar_q   <= `ASC_RES_RST;
			bit_q   <= 4'd0;
		end else if (ce) begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			idx_q   <= idx_d;
			first_q <= first_d;
			sar_q   <= sar_d;
			bit_q   <= bit_d;
		end
	end

	// Control/status and trigger control registers
	always @(posedge clk_sys) begin
		if (srst) begin
			{flag_q, ie_q, start_q, scan_q, speed_q, group_q,
				chan_q} <= `ASC_CTRL_RST;
			ext_en_q <= TRIG_RST[`ASC_TRIG_EXT];             // [RL1]
			arm_q    <= 1'b0;
		end else if (ce) begin
			if (wr_trig)
				ext_en_q <= bus_wdata[`ASC_TRIG_EXT];        // [RL2] [RL3]
			// Start bit: a hardware set beats both clears
			if (clr_start)
				start_q <= 1'b0;
			if (wr_ctrl) begin
				ie_q    <= bus_wdata[`ASC_CTRL_IE];
				start_q <= bus_wdata[`ASC_CTRL_START];
				scan_q  <= bus_wdata[`ASC_CTRL_SCAN];
				speed_q <= bus_wdata[`ASC_CTRL_SPEED];
				group_q <= bus_wdata[`ASC_CTRL_GROUP];
				chan_q  <= bus_wdata[1:0];
			end
			if (trig_go)
				start_q <= 1'b1;                             // [RL19]
			// Flag clears only after it was read as one
			if (wr_ctrl)
				arm_q <= 1'b0;
			else if (rd_p_q && raddr_q == `ASC_ADR_CTRL && flag_q)
				arm_q <= 1'b1;                               // [RL10]
			if (wr_ctrl && arm_q && !bus_wdata[`ASC_CTRL_FLAG])
				flag_q <= 1'b0;                              // [RL10]
			if (set_flag)
				flag_q <= 1'b1;                              // [RL9]
		end
	end

	// Read pipeline: store read at cycle 0, data and valid at cycle 2
	always @(posedge clk_sys) begin
		if (srst) begin
			rd_p_q     <= 1'b0;
			raddr_q    <= 8'h00;
			bus_rdata  <= 8'h00;
			bus_rvalid <= 1'b0;
			temp_q     <= 8'h00;
		end else if (ce) begin
			rd_p_q     <= bus_rd;
			raddr_q    <= bus_addr;
			bus_rvalid <= rd_p_q;
			if (rd_p_q) begin
				if (is_res(raddr_q) && !raddr_q[0]) begin
					bus_rdata <= mem_rdata[9:2];             // [RL4] [RL22]
					temp_q    <= {mem_rdata[1:0], 6'd0};     // [RL4] [RL22]
				end else if (is_res(raddr_q)) begin
					bus_rdata <= temp_q;                     // [RL5] [RL6]
				end else if (raddr_q == `ASC_ADR_CTRL) begin
					bus_rdata <= {flag_q, ie_q, start_q, scan_q,
						speed_q, group_q, chan_q};
				end else if (raddr_q == `ASC_ADR_TRIG) begin
					bus_rdata <= {ext_en_q, `ASC_TRIG_RSVD}; // [RL3]
				end else begin
					bus_rdata <= 8'h00;
				end
			end
		end
	end

	// Result registers A-D, indexed by position within the group
	asc_result_mem #(
		.DW(RES_W),
		.AW(2)
	) u_mem (
		.clk_sys (clk_sys),
		.srst    (srst),
		.ce      (ce),
		.we      (mem_we),
		.waddr   (cur),
		.wdata   (sar_q),
		.re      (bus_rd & is_res(bus_addr)),
		.raddr   (res_idx(bus_addr)),
		.rdata   (mem_rdata)
	);
endmodule

//--- rtl/asc_defines.vh
// Constants for the converter sequencer: bus offsets, field positions,
// reset values and conversion timing in peripheral clock states.
// Assumes an 8-bit bus whose low address byte selects the register.
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// Byte offsets on the 8-bit bus (low address byte)
`define ASC_ADR_RES_BASE  8'he0
`define ASC_ADR_CTRL      8'he8
`define ASC_ADR_TRIG      8'he9

// Fields of the conversion control/status register
`define ASC_CTRL_FLAG     7
`define ASC_CTRL_IE       6
`define ASC_CTRL_START    5
`define ASC_CTRL_SCAN     4
`define ASC_CTRL_SPEED    3
`define ASC_CTRL_GROUP    2

// Fields of the trigger control register
`define ASC_TRIG_EXT      7

// Reset values
`define ASC_CTRL_RST      8'h00
`define ASC_TRIG_RST      8'h7f
`define ASC_TRIG_RSVD     7'h7f
`define ASC_RES_RST       10'h000

// Timing in states, slow (speed select 0) and fast (speed select 1)
`define ASC_SLOW_DLY_MIN  9'd10
`define ASC_SLOW_DLY_MAX  9'd17
`define ASC_FAST_DLY_MIN  9'd6
`define ASC_FAST_DLY_MAX  9'd9
`define ASC_SLOW_SAMPLE   9'd80
`define ASC_FAST_SAMPLE   9'd40
`define ASC_SLOW_CONV_MAX 9'd266
`define ASC_FAST_CONV_MAX 9'd134
`define ASC_SLOW_SCAN     9'd256
`define ASC_FAST_SCAN     9'd128

// Successive approximation: one decision every 8 states, last 80 states
`define ASC_SAR_WINDOW    9'd80
`define ASC_SAR_MSB       10'h200

`endif

//--- rtl/asc_result_mem.v
// Result store: one word per result register, registered read data.
// Assumes a single clock; reset and standby clear every word.
`timescale 1ns/1ps
`include "asc_defines.vh"

module asc_result_mem #(
	parameter DW = 10,
	parameter AW = 2
) (
	input  wire          clk_sys,
	input  wire          srst,
	input  wire          ce,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	input  wire          re,
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata
);
	reg [DW-1:0] mem_q [0:(1<<AW)-1];
	integer      i;

	// Write-before-read is not needed: a CPU read racing a store sees old data
	always @(posedge clk_sys) begin
		if (srst) begin
			for (i = 0; i < (1 << AW); i = i + 1)
				mem_q[i] <= {DW{1'b0}};
			rdata <= {DW{1'b0}};
		end else if (ce) begin
			if (we)
				mem_q[waddr] <= wdata;
			if (re)
				rdata <= mem_q[raddr];
		end
	end
endmodule

//--- testbench/asc_seq_monitor.sv
// Port checker for the converter sequencer.
// Assumes ce held high; bound into every sequencer instance.
`timescale 1ns/1ps
`include "asc_defines.vh"
module asc_seq_monitor (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       standby,
	input wire logic       periph_half,
	input wire logic [7:0] bus_addr,
	input wire logic       bus_rd,
	input wire logic       bus_wr,
	input wire logic [7:0] bus_rdata,
	input wire logic       bus_rvalid,
	input wire logic [2:0] analog_sel,
	input wire logic       sample_hold,
	input wire logic [9:0] dac_code,
	input wire logic       conv_end_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [8:0] smp_q;
	// Length of the running sample phase in states
	always @(posedge clk_sys) begin
		if (!rstn || !sample_hold)
			smp_q <= 9'd0;
		else
			smp_q <= smp_q + 9'd1;
	end
	a_read_answer: assert property (bus_rd |-> ##2 bus_rvalid)
		else $error("read not answered");
	a_no_stray: assert property (!bus_rd |-> ##2 !bus_rvalid)
		else $error("answer without read");
	a_trig_ones: assert property (
		bus_rvalid && $past(bus_addr, 2) == `ASC_ADR_TRIG
		|-> bus_rdata[6:0] == 7'h7f) else $error("trigger bits low");
	a_low_zero: assert property (
		bus_rvalid && $past(bus_addr, 2) inside {8'he1, 8'he3, 8'he5, 8'he7}
		|-> bus_rdata[5:0] == 6'h00) else $error("low bits set");
	a_sample_len: assert property (
		// A halting write two cycles back may cut a sample short
		$fell(sample_hold) && !periph_half && !$past(standby) &&
		!$past(bus_wr, 2)
		|-> smp_q == 9'd80 || smp_q == 9'd40) else $error("sample length");
	a_sel_steady: assert property (
		sample_hold && $past(sample_hold) |-> $stable(analog_sel))
		else $error("input moved in sample");
	a_standby_clr: assert property (
		standby |=> !sample_hold && dac_code == 10'h000 && !conv_end_irq)
		else $error("standby did not clear");
	a_rdata_hold: assert property (
		!bus_rvalid && !$past(standby) |-> $stable(bus_rdata))
		else $error("read data moved");
	c_sample: cover property ($rose(sample_hold));
	c_irq: cover property ($rose(conv_end_irq));
	c_trig: cover property (bus_rvalid && $past(bus_addr, 2) == `ASC_ADR_TRIG);
endmodule
bind asc_sequencer asc_seq_monitor asc_seq_monitor_i (.*);

//--- testbench/asc_analog_model.sv
// Far side: eight ideal analog inputs and the comparator.
// Assumes the bench sets each input as a 10-bit level code.
`timescale 1ns/1ps
module asc_analog_model (
	input  wire logic [2:0] analog_sel,
	input  wire logic [9:0] dac_code,
	output logic            cmp_in
);
	int level [8];
	// Ideal comparator answers at once, so any slip is the sequencer's
	assign cmp_in = level[analog_sel] >= int'(dac_code);
endmodule

//--- testbench/test_adc_sequencer_control.sv
// Bench for the sequencer: registers, single, scan, trigger, standby.
// Assumes ce high and full-rate states throughout.
`timescale 1ns/1ps
`include "asc_defines.vh"
`define CHK(g, e) check_val(16'(g), 16'(e))
module test_adc_sequencer_control;
	logic       clk_sys = 0;
	logic       rstn = 0;
	logic       standby = 0;
	logic       bus_rd = 0;
	logic       bus_wr = 0;
	logic       trigger_pin_n = 1;
	logic       sh_q = 0;
	logic [7:0] bus_addr = 0;
	logic [7:0] bus_wdata = 0;
	logic [7:0] bus_rdata, rd_v;
	logic       bus_rvalid, sample_hold, conv_end_irq, cmp_in;
	logic [2:0] analog_sel;
	logic [9:0] dac_code;
	int         err_total = 0, checks_done = 0, n, e;
	logic [2:0] sel_q[$];
	int         at_q[$];
	localparam  CTRL = `ASC_ADR_CTRL, TRIG = `ASC_ADR_TRIG;
	asc_sequencer asc_sequencer_i (
		.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .standby(standby),
		.periph_half(1'b0), .bus_addr(bus_addr), .bus_rd(bus_rd),
		.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_rvalid(bus_rvalid), .trigger_pin_n(trigger_pin_n),
		.cmp_in(cmp_in), .analog_sel(analog_sel),
		.sample_hold(sample_hold), .dac_code(dac_code),
		.conv_end_irq(conv_end_irq));
	asc_analog_model asc_analog_model_i (
		.analog_sel(analog_sel), .dac_code(dac_code), .cmp_in(cmp_in));
	always #50 clk_sys = ~clk_sys;
	// Log the input and the state of every sample start
	always @(posedge clk_sys) begin
		if (sample_hold && !sh_q) begin
			sel_q.push_back(analog_sel);
			at_q.push_back(int'($time / 100));
		end
		sh_q <= sample_hold;
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check_val(input logic [15:0] g, input logic [15:0] x);
		checks_done++;
		if (g !== x) begin
			err_total++;
			$display("wrong value at %0t: %h expected %h", $time, g, x);
		end
	endtask
	// One state; a wait that runs too long ends the run
	task automatic tick();
		@(posedge clk_sys);
		#1;
		n++;
		if (n > 1000) begin
			err_total++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		bus_wr = 1;
		bus_addr = a;
		bus_wdata = d;
		@(posedge clk_sys);
		#1;
		bus_wr = 0;
	endtask
	// Data holds after the answer, so sampling late is safe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		#1;
		bus_rd = 1;
		bus_addr = a;
		@(posedge clk_sys);
		#1;
		bus_rd = 0;
		repeat (2) @(posedge clk_sys);
		#1 rd_v = bus_rdata;
	endtask
	task automatic chk_res(input int r, input int v);
		rd(8'(`ASC_ADR_RES_BASE + 2 * r));
		`CHK(rd_v, v >> 2);
		rd(8'(`ASC_ADR_RES_BASE + 2 * r + 1));
		`CHK(rd_v, (v & 3) << 6);
	endtask
	initial begin
		n = $urandom(13);
		repeat (5) @(posedge clk_sys);
		#1 rstn = 1;
		rd(TRIG);
		`CHK(rd_v, `ASC_TRIG_RST);
		rd(CTRL);
		`CHK(rd_v, `ASC_CTRL_RST);
		wr(TRIG, 8'h00);
		rd(TRIG);
		`CHK(rd_v, 8'h7f);
		// Single: input 1 slow, then input 5 fast
		for (int s = 0; s < 2; s++) begin
			e = $urandom % 1024;
			asc_analog_model_i.level[s * 4 + 1] = e;
			wr(CTRL, 8'(8'h61 | s << 3 | s << 2));
			n = 0;
			while (conv_end_irq !== 1'b1) tick();
			`CHK(n >= (s ? 131 : 259) && n <= (s ? 134 : 266), 1);
			wr(CTRL, 8'(8'h41 | s << 3 | s << 2));
			rd(CTRL);
			`CHK(rd_v, 8'hc1 | s << 3 | s << 2);
			wr(CTRL, 8'(8'h41 | s << 3 | s << 2));
			rd(CTRL);
			`CHK(rd_v, 8'h41 | s << 3 | s << 2);
			chk_res(1, e);
		end
		// Scan of inputs 4 to 6, fast
		for (int c = 4; c < 7; c++)
			asc_analog_model_i.level[c] = $urandom % 1024;
		sel_q.delete();
		at_q.delete();
		wr(CTRL, 8'h7e);
		n = 0;
		while (conv_end_irq !== 1'b1) tick();
		for (int c = 0; c < 3; c++)
			chk_res(c, asc_analog_model_i.level[c + 4]);
		n = 0;
		while (sel_q.size() < 4) tick();
		for (int c = 0; c < 4; c++)
			`CHK(sel_q[c], c == 3 ? 4 : c + 4);
		`CHK(at_q[2] - at_q[1], 128);
		`CHK(at_q[3] - at_q[2], 128);
		// Halt while converting the second input, so a stale index shows
		while (sel_q.size() < 5) tick();
		`CHK(sel_q[4], 5);
		while (sample_hold !== 1'b0) tick();
		wr(CTRL, 8'h5e);
		sel_q.delete();
		wr(CTRL, 8'h7e);
		n = 0;
		while (sel_q.size() < 1) tick();
		`CHK(sel_q[0], 4);
		while (sample_hold !== 1'b0) tick();
		rd(CTRL);
		wr(CTRL, 8'h40);
		// Trigger pin ignored while disabled, then starts input 0
		e = $urandom % 1024;
		asc_analog_model_i.level[0] = e;
		trigger_pin_n = 0;
		repeat (20) @(posedge clk_sys);
		#1 trigger_pin_n = 1;
		rd(CTRL);
		`CHK(rd_v, 8'h40);
		wr(TRIG, 8'h80);
		rd(TRIG);
		`CHK(rd_v, 8'hff);
		trigger_pin_n = 0;
		n = 0;
		while (conv_end_irq !== 1'b1) tick();
		trigger_pin_n = 1;
		chk_res(0, e);
		// Standby acts as reset
		standby = 1;
		repeat (2) @(posedge clk_sys);
		#1 standby = 0;
		rd(TRIG);
		`CHK(rd_v, 8'h7f);
		rd(CTRL);
		`CHK(rd_v, 8'h00);
		chk_res(0, 0);
		finish_test();
	end
endmodule
